// File: core/wdc_watchdog_control.sv
// watchdog timer control register and count logic
// assumes fuse inputs are static straps; register port on sys_clk
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module wdc_watchdog_control #(
	parameter int unsigned TICK_CYCLES = wdc_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// configuration fuses
	input wire logic fuse_enable,
	input wire logic [wdc_pkg::PS_W-1:0] postscale_fuse,
	// register port
	input wire logic [wdc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [wdc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [wdc_pkg::DATA_W-1:0] reg_rdata,
	// status
	output logic running,
	output logic window_mode,
	output logic wdt_reset
);
	import wdc_pkg::*;

	logic sw_on_q;
	logic win_q;
	logic [PS_W-1:0] postscale_shadow_q;
	logic shadow_loaded_q;
	logic fuse_en_q;
	logic [CNT_W-1:0] tick_q;
	logic [CNT_W-1:0] post_q;
	logic [CNT_W-1:0] post_lim;
	logic wr_ctl;
	logic clr_req;
	logic on_now;
	logic [DATA_W-1:0] rd_val;

	assign wr_ctl = reg_wr && (reg_addr == OFS_CONTROL);
	assign clr_req = wr_ctl && reg_wdata[BIT_CLR];
	assign on_now = fuse_en_q || sw_on_q;
	assign post_lim = (postscale_shadow_q > PS_W'(PS_MAX)) ? (CNT_W'(1) << PS_MAX)
		: (CNT_W'(1) << postscale_shadow_q);

	////////////////////////////////////////////////////////////////////////////////
	// fuse capture after reset release; straps are static, no synchroniser needed
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shadow_loaded_q <= 1'b0;
			postscale_shadow_q <= '0;
			fuse_en_q <= 1'b0;
		end else if (!shadow_loaded_q) begin
			shadow_loaded_q <= 1'b1;
			postscale_shadow_q <= postscale_fuse;
			fuse_en_q <= fuse_enable;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sw_on_q <= 1'b0;
			win_q <= 1'b0;
		end else if (wr_ctl) begin
			sw_on_q <= reg_wdata[BIT_ON];
			win_q <= reg_wdata[BIT_WIN];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// count: base tick times 2^postscale, postscale capped at PS_MAX
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_q <= '0;
			post_q <= '0;
			wdt_reset <= 1'b0;
		end else if (!on_now || clr_req || !shadow_loaded_q) begin
			tick_q <= '0;
			post_q <= '0;
			wdt_reset <= 1'b0;
		end else if (tick_q >= CNT_W'(TICK_CYCLES - 1)) begin
			tick_q <= '0;
			if (post_q >= post_lim - CNT_W'(1)) begin
				post_q <= '0;
				wdt_reset <= 1'b1;
			end else begin
				post_q <= post_q + CNT_W'(1);
				wdt_reset <= 1'b0;
			end
		end else begin
			tick_q <= tick_q + CNT_W'(1);
			wdt_reset <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// readback; clear bit always reads zero
	always_comb begin
		rd_val = '0;
		if (reg_addr == OFS_CONTROL) begin
			rd_val[BIT_ON] = on_now;
			rd_val[PS_MSB:PS_LSB] = postscale_shadow_q;
			rd_val[BIT_WIN] = win_q;
		end
	end

	// read data stand for one cycle only; idle bus reads back zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rd_val;
		end else begin
			reg_rdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status outputs, one cycle behind the live state so they come from flops
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			running <= 1'b0;
		end else begin
			running <= on_now;
		end
	end

	// window mode is only exported; no early-clear window check is made here
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			window_mode <= 1'b0;
		end else begin
			window_mode <= win_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	chk_sw_enable: assert property (@(posedge sys_clk) disable iff (!arst_n)
		wr_ctl && reg_wdata[BIT_ON] |=> sw_on_q)
		else $error("software enable not set");
	chk_fuse_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		fuse_en_q && wr_ctl && !reg_wdata[BIT_ON] |=> running)
		else $error("fuse enable lost");
	chk_sw_disable: assert property (@(posedge sys_clk) disable iff (!arst_n)
		wr_ctl && !reg_wdata[BIT_ON] |=> !sw_on_q)
		else $error("software disable not taken");
	chk_run_track: assert property (@(posedge sys_clk) disable iff (!arst_n)
		1'b1 |=> running == $past(on_now))
		else $error("running output lags wrongly");
	chk_on_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_rd && reg_addr == OFS_CONTROL |=> reg_rdata[BIT_ON] == $past(on_now))
		else $error("enable readback wrong");
	chk_shadow_ro: assert property (@(posedge sys_clk) disable iff (!arst_n)
		shadow_loaded_q |=> $stable(postscale_shadow_q))
		else $error("shadow changed");
	chk_win_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
		wr_ctl |=> win_q == $past(reg_wdata[BIT_WIN]))
		else $error("window bit not stored");
	chk_clr_restart: assert property (@(posedge sys_clk) disable iff (!arst_n)
		clr_req |=> tick_q == '0 && post_q == '0 && !wdt_reset)
		else $error("clear did not restart");
	chk_clr_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_rd |=> !reg_rdata[BIT_CLR])
		else $error("clear bit read one");
	chk_unimpl_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_rd |=> reg_rdata[31:16] == '0 && reg_rdata[14:7] == '0)
		else $error("unimplemented bits nonzero");
	chk_off_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!on_now |=> !wdt_reset)
		else $error("reset while disabled");

	// shadow load and window output behaviour
	chk_shadow_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!shadow_loaded_q |=> postscale_shadow_q == $past(postscale_fuse))
		else $error("shadow not loaded from fuse");
	chk_win_out: assert property (@(posedge sys_clk) disable iff (!arst_n)
		1'b1 |=> window_mode == $past(win_q))
		else $error("window output wrong");

	// a zero in the clear bit must let the count run on
	chk_clr_ignore: assert property (@(posedge sys_clk) disable iff (!arst_n)
		wr_ctl && !reg_wdata[BIT_CLR] && on_now && shadow_loaded_q && tick_q < CNT_W'(TICK_CYCLES - 1)
		|=> tick_q == $past(tick_q) + CNT_W'(1))
		else $error("zero clear restarted count");

	// readback of idle bus and foreign addresses
	chk_rd_other: assert property (@(posedge sys_clk) disable iff (!arst_n)
		reg_rd && reg_addr != OFS_CONTROL |=> reg_rdata == '0)
		else $error("foreign address read nonzero");
	chk_rd_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!reg_rd |=> reg_rdata == '0)
		else $error("read data outside read cycle");

	// counter bounds; a stuck counter would otherwise never expire
	chk_off_stop: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!on_now |=> tick_q == '0 && post_q == '0)
		else $error("count runs while disabled");
	chk_expire_restart: assert property (@(posedge sys_clk) disable iff (!arst_n)
		wdt_reset |-> tick_q == '0 && post_q == '0)
		else $error("count not restarted at expiry");
	chk_tick_bound: assert property (@(posedge sys_clk) disable iff (!arst_n)
		tick_q < CNT_W'(TICK_CYCLES))
		else $error("base tick overran");
	chk_post_bound: assert property (@(posedge sys_clk) disable iff (!arst_n)
		post_q < post_lim)
		else $error("postscale count overran");

	// main scenarios
	cov_sw_on: cover property (@(posedge sys_clk) disable iff (!arst_n) wr_ctl && reg_wdata[BIT_ON]);
	cov_clear: cover property (@(posedge sys_clk) disable iff (!arst_n) clr_req && on_now);
	cov_expire: cover property (@(posedge sys_clk) disable iff (!arst_n) wdt_reset);
	cov_fuse_forced: cover property (@(posedge sys_clk) disable iff (!arst_n) fuse_en_q && wr_ctl && !reg_wdata[BIT_ON]);
	cov_win_set: cover property (@(posedge sys_clk) disable iff (!arst_n) wr_ctl && reg_wdata[BIT_WIN]);
endmodule

// File: core/wdc_pkg.sv
// watchdog control package: register offset, field positions, timing constants
// assumes a 32-bit register port and a 20 MHz system clock
package wdc_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
	localparam int unsigned BIT_ON = 15;
	localparam int unsigned PS_LSB = 2;
	localparam int unsigned PS_MSB = 6;
	localparam int unsigned BIT_WIN = 1;
	localparam int unsigned BIT_CLR = 0;
	localparam int unsigned PS_W = 5;
	// base timeout tick, before postscaling
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYC = (CLK_HZ / 1000000) * TICK_US;
	localparam int unsigned PS_MAX = 20;
	localparam int unsigned CNT_W = 32;
	localparam int unsigned RST_PULSE = 1;
endpackage

// File: testbench/tb_wdc_watchdog_control.sv
// bench for the watchdog control register and count logic
// assumes a short base tick (4 cycles) so expiry fits a quick run
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_wdc_watchdog_control;
	import wdc_pkg::*;
	logic sys_clk = 0, arst_n = 0, fuse_enable = 0, reg_wr = 0, reg_rd = 0;
	logic [PS_W-1:0] postscale_fuse = 5'h02;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
	logic running, window_mode, wdt_reset;
	int fails = 0, cmp_count = 0, n;
	wdc_watchdog_control #(.TICK_CYCLES(4)) u_wdc_watchdog_control (.sys_clk(sys_clk), .arst_n(arst_n),
		.fuse_enable(fuse_enable), .postscale_fuse(postscale_fuse), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .running(running),
		.window_mode(window_mode), .wdt_reset(wdt_reset));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic do_reset();
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge sys_clk);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask
	// counts edges until the expiry pulse, bounded so a dead counter cannot hang
	task automatic wait_expiry(output int cnt);
		cnt = 0;
		while (wdt_reset !== 1'b1 && cnt < 60) begin
			@(posedge sys_clk);
			#1 cnt++;
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#150000;
		fails++;
		complete_run();
	end
	initial begin
		do_reset();
		rd(4'h0, 32'h0000_0008);
		`CHK(running, 1'b0)
		wr(4'h0, 32'hffff_ffff);
		rd(4'h0, 32'h0000_800a);
		`CHK({running, window_mode}, 2'b11)
		rd(4'h4, 32'h0);
		wr(4'h0, 32'h0000_8001);
		wait_expiry(n);
		`CHK(n >= 14 && n <= 18, 1'b1)
		@(posedge sys_clk);
		#1 `CHK(wdt_reset, 1'b0)
		// periodic clears must hold off the expiry pulse
		repeat (5) begin
			wr(4'h0, 32'h0000_8001);
			repeat (8) @(posedge sys_clk);
			`CHK(wdt_reset, 1'b0)
		end
		// a zero clear bit must not restart: expiry about 6 edges on, not 16
		wr(4'h0, 32'h0000_8000);
		wait_expiry(n);
		`CHK(n <= 10, 1'b1)
		wr(4'h0, 32'h0000_0000);
		@(posedge sys_clk);
		#1 `CHK(running, 1'b0)
		wr(4'h0, 32'h0000_0001);
		rd(4'h0, 32'h0000_0008);
		`CHK(window_mode, 1'b0)
		// fuse forced enable: software cannot stop it
		fuse_enable <= 1'b1;
		postscale_fuse <= 5'h03;
		do_reset();
		rd(4'h0, 32'h0000_800c);
		wr(4'h0, 32'h0000_0000);
		@(posedge sys_clk);
		rd(4'h0, 32'h0000_800c);
		`CHK(running, 1'b1)
		complete_run();
	end
endmodule
